/* File: rtl/crm_pkg.sv */
// ============================================================================
// Shared constants for the custom reference monitor configuration bank.
package crm_pkg;

  // ==========================================================================
  // Register addresses on the internal register port (byte addresses).
  localparam logic [7:0] CRM_ADDR_FREQ_MODE_0 = 8'h65; // Reference 0..3 mode fields.
  localparam logic [7:0] CRM_ADDR_FREQ_MODE_1 = 8'h66; // Reference 4 mode field.
  localparam logic [7:0] CRM_ADDR_A_MULT_LO = 8'h67; // Profile A multiplier, low byte.
  localparam logic [7:0] CRM_ADDR_A_MULT_HI = 8'h68; // Profile A multiplier, upper six bits.
  localparam logic [7:0] CRM_ADDR_A_PER_LOW = 8'h69; // Profile A single-cycle low limit.
  localparam logic [7:0] CRM_ADDR_A_PER_HIGH = 8'h6A; // Profile A single-cycle high limit.
  localparam logic [7:0] CRM_ADDR_A_FRQ_LOW_LO = 8'h6B; // Profile A frequency low limit, bits 7:0.
  localparam logic [7:0] CRM_ADDR_A_FRQ_LOW_HI = 8'h6C; // Profile A frequency low limit, bits 15:8.
  localparam logic [7:0] CRM_ADDR_A_FRQ_HIGH_LO = 8'h6D; // Profile A frequency high limit, bits 7:0.
  localparam logic [7:0] CRM_ADDR_A_FRQ_HIGH_HI = 8'h6E; // Profile A frequency high limit, bits 15:8.
  localparam logic [7:0] CRM_ADDR_A_CYCLES = 8'h6F; // Profile A monitored cycles minus one.
  localparam logic [7:0] CRM_ADDR_A_PRESCALE = 8'h70; // Profile A divide-by-4 enable.
  localparam logic [7:0] CRM_ADDR_B_MULT_LO = 8'h71; // Profile B multiplier, low byte.
  localparam logic [7:0] CRM_ADDR_B_MULT_HI = 8'h72; // Profile B multiplier, upper six bits.
  localparam logic [7:0] CRM_ADDR_B_PER_LOW = 8'h73; // Profile B single-cycle low limit.
  localparam logic [7:0] CRM_ADDR_B_PER_HIGH = 8'h74; // Profile B single-cycle high limit.

  // The bank is one contiguous run of flip-flops indexed from the first address.
  localparam logic [7:0] CRM_BASE = CRM_ADDR_FREQ_MODE_0;
  localparam logic [7:0] CRM_LAST = CRM_ADDR_B_PER_HIGH;
  localparam int CRM_NUM_REGS = 16;
  localparam int CRM_IDX_W = 4;

  // ==========================================================================
  // Reset value and field layout.
  localparam logic [7:0] CRM_RESET_VAL = 8'h00; // Every register resets to zero.
  localparam logic [7:0] CRM_MASK_FULL = 8'hFF; // Fully writable byte.
  localparam logic [7:0] CRM_MASK_MULT_HI = 8'h3F; // Multiplier bits 13:8 sit in bits 5:0.
  localparam logic [7:0] CRM_MASK_MODE_1 = 8'h03; // Only reference 4 lives in the second mode register.
  localparam logic [7:0] CRM_MASK_PRESCALE = 8'h01; // Prescale enable is bit 0.
  localparam int CRM_NUM_REFS = 5; // Reference inputs under monitoring.
  localparam int CRM_MODE_W = 2; // Width of one reference mode field.
  localparam int CRM_MULT_W = 14; // Expected frequency in 8 kHz units.
  localparam int CRM_PER_W = 8; // Single-cycle limit width.
  localparam int CRM_FRQ_W = 16; // Cycle-frequency limit width.
  localparam logic [1:0] CRM_PRESCALE_LAST = 2'h3; // Last edge of a divide-by-4 group.

  // Reference mode encodings.
  typedef enum logic [1:0] {
    CRM_MODE_AUTO = 2'b00,
    CRM_MODE_PROF_A = 2'b01,
    CRM_MODE_PROF_B = 2'b10,
    CRM_MODE_RSVD = 2'b11
  } crm_mode_t;

  // Writable-bit mask for each register index; reserved bits are held at zero.
  function automatic logic [7:0] crm_wmask(input logic [CRM_IDX_W-1:0] idx);
    logic [7:0] addr;
    addr = CRM_BASE + {4'h0, idx};
    case (addr)
      CRM_ADDR_FREQ_MODE_1: crm_wmask = CRM_MASK_MODE_1;
      CRM_ADDR_A_MULT_HI: crm_wmask = CRM_MASK_MULT_HI;
      CRM_ADDR_B_MULT_HI: crm_wmask = CRM_MASK_MULT_HI;
      CRM_ADDR_A_PRESCALE: crm_wmask = CRM_MASK_PRESCALE;
      default: crm_wmask = CRM_MASK_FULL;
    endcase
  endfunction

endpackage

/* File: rtl/crm_ref_mon.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Monitor for one reference input against the limits of its selected profile.
module crm_ref_mon (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ref_i,
  input wire logic enable_i,
  input wire logic freq_check_i,
  input wire logic prescale_i,
  input wire logic [7:0] per_low_i,
  input wire logic [7:0] per_high_i,
  input wire logic [15:0] frq_low_i,
  input wire logic [15:0] frq_high_i,
  input wire logic [7:0] cycles_i,
  output logic fail_o
);

  logic ref_q; // Previous reference level for edge detection.
  logic [1:0] div_q; // Divide-by-4 edge counter.
  logic [7:0] per_q; // System clocks since the last reference edge.
  logic per_seen_q; // At least one edge seen, so a period is measurable.
  logic per_fail_q; // Single-cycle monitor verdict.
  logic [15:0] win_q; // System clocks inside the frequency window.
  logic [7:0] cyc_q; // Monitored edges counted in this window.
  logic win_run_q; // Window has been opened by a first edge.
  logic frq_fail_q; // Cycle-frequency monitor verdict.
  logic edge_w;
  logic mon_edge_w;

  assign edge_w = ref_i & ~ref_q;
  // With prescale only every fourth rising edge counts, stretching the window.
  assign mon_edge_w = prescale_i ? (edge_w && (div_q == crm_pkg::CRM_PRESCALE_LAST)) : edge_w;

  // ==========================================================================
  // Edge capture and prescaler.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_q <= 1'b0;
      div_q <= 2'h0;
    end else begin
      ref_q <= ref_i;
      // The prescaler restarts whenever the profile is off so windows align.
      if (!enable_i) begin
        div_q <= 2'h0;
      end else if (edge_w) begin
        div_q <= div_q + 2'h1;
      end
    end
  end

  // ==========================================================================
  // Single-cycle monitor: period between raw edges against the 8-bit limits.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      per_q <= 8'h00;
      per_seen_q <= 1'b0;
      per_fail_q <= 1'b0;
    end else if (!enable_i) begin
      per_q <= 8'h00;
      per_seen_q <= 1'b0;
      per_fail_q <= 1'b0;
    end else if (edge_w) begin
      // A short period is judged at the edge that ends it.
      if (per_seen_q) begin
        per_fail_q <= (per_q < per_low_i) || (per_q > per_high_i);
      end
      per_q <= 8'h00;
      per_seen_q <= 1'b1;
    end else begin
      // A lost reference is flagged as soon as the high limit is passed.
      if (per_seen_q && (per_q > per_high_i)) begin
        per_fail_q <= 1'b1;
      end
      if (per_q != 8'hFF) begin
        per_q <= per_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // Cycle-frequency monitor: clocks spanned by cycles_i plus one monitored cycles.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      win_q <= 16'h0000;
      cyc_q <= 8'h00;
      win_run_q <= 1'b0;
      frq_fail_q <= 1'b0;
    end else if (!enable_i || !freq_check_i) begin
      win_q <= 16'h0000;
      cyc_q <= 8'h00;
      win_run_q <= 1'b0;
      frq_fail_q <= 1'b0;
    end else if (mon_edge_w) begin
      if (win_run_q && (cyc_q == cycles_i)) begin
        // Window closes after cycles_i plus one monitored cycles.
        frq_fail_q <= (win_q < frq_low_i) || (win_q > frq_high_i);
        cyc_q <= 8'h00;
        win_q <= 16'h0001;
      end else if (win_run_q) begin
        // Inner edges keep counting, so the window spans every cycle in it.
        cyc_q <= cyc_q + 8'h01;
        if (win_q != 16'hFFFF) begin
          win_q <= win_q + 16'h0001;
        end
      end else begin
        // The first monitored edge opens the window.
        win_q <= 16'h0001;
      end
      win_run_q <= 1'b1;
    end else if (win_run_q && (win_q != 16'hFFFF)) begin
      win_q <= win_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Combined verdict, registered so the top-level output is a flop.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fail_o <= 1'b0;
    end else begin
      fail_o <= enable_i && (per_fail_q || frq_fail_q);
    end
  end

endmodule
`default_nettype wire

/* File: rtl/crm_reg_bank.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Profile B multiplier: 14 bits over two registers.
// - Profile A single-cycle low limit, 8 bits.
// - Profile A single-cycle high limit, 8 bits.
// - Profile B single-cycle low limit, 8 bits.
// - Profile A frequency low limit, 16 bits.
// - Profile A frequency high limit, 16 bits.
// - Monitored cycle count equals programmed value plus one.
// - Prescale bit divides reference by four.
// - Two-bit mode per reference: auto, A, B.
// - Profile A multiplier: 14 bits over two registers.
module crm_reg_bank (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [4:0] ref_clk_i,
  output logic [7:0] reg_rdata_o,
  output logic [4:0] ref_fail_o,
  output logic [9:0] input_frequency_select_o,
  output logic [13:0] prof_a_multiplier_o,
  output logic [13:0] prof_b_multiplier_o
);

  // ==========================================================================
  // Storage and decode.
  logic [7:0] regs_q [crm_pkg::CRM_NUM_REGS]; // Register bank, indexed from the base address.
  logic hit_w; // Address falls inside the bank.
  logic [crm_pkg::CRM_IDX_W-1:0] idx_w; // Index of the addressed register.
  logic [7:0] off_w; // Byte offset from the base address.

  assign hit_w = (reg_addr_i >= crm_pkg::CRM_BASE) && (reg_addr_i <= crm_pkg::CRM_LAST);
  assign off_w = reg_addr_i - crm_pkg::CRM_BASE;
  assign idx_w = off_w[crm_pkg::CRM_IDX_W-1:0];

  // Helper to read a register by its address constant.
  function automatic logic [7:0] rd(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - crm_pkg::CRM_BASE;
    rd = regs_q[off[crm_pkg::CRM_IDX_W-1:0]];
  endfunction

  // ==========================================================================
  // Register writes. Reserved bits are masked off, so a careless write of a
  // one there can never select an undefined setting; they read back as zero.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < crm_pkg::CRM_NUM_REGS; i++) begin
        regs_q[i] <= crm_pkg::CRM_RESET_VAL;
      end
    end else if (reg_wr_i && hit_w) begin
      // ..storage; masks enforce in hardware.
      regs_q[idx_w] <= reg_wdata_i & crm_pkg::crm_wmask(idx_w);
    end
  end

  // ==========================================================================
  // Read port: one cycle after the strobe; unmapped addresses return zero.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (hit_w) begin
        reg_rdata_o <= regs_q[idx_w];
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Assembled configuration fields handed to the frequency logic. These are
  // wires off the bank flops, so the outputs still come straight from flops.
  logic [15:0] a_frq_low_w; // Profile A frequency low limit.
  logic [15:0] a_frq_high_w; // Profile A frequency high limit.
  logic [7:0] a_mult_hi_w; // Profile A multiplier upper byte.
  logic [7:0] b_mult_hi_w; // Profile B multiplier upper byte.
  logic [7:0] mode_hi_w; // Second mode register, reference 4 in bits 1:0.

  assign a_frq_low_w = {rd(crm_pkg::CRM_ADDR_A_FRQ_LOW_HI), rd(crm_pkg::CRM_ADDR_A_FRQ_LOW_LO)};
  assign a_frq_high_w = {rd(crm_pkg::CRM_ADDR_A_FRQ_HIGH_HI), rd(crm_pkg::CRM_ADDR_A_FRQ_HIGH_LO)};
  assign a_mult_hi_w = rd(crm_pkg::CRM_ADDR_A_MULT_HI);
  assign b_mult_hi_w = rd(crm_pkg::CRM_ADDR_B_MULT_HI);
  assign prof_a_multiplier_o = {a_mult_hi_w[5:0], rd(crm_pkg::CRM_ADDR_A_MULT_LO)};
  assign prof_b_multiplier_o = {b_mult_hi_w[5:0], rd(crm_pkg::CRM_ADDR_B_MULT_LO)};
  assign mode_hi_w = rd(crm_pkg::CRM_ADDR_FREQ_MODE_1) & crm_pkg::CRM_MASK_MODE_1;
  assign input_frequency_select_o = {mode_hi_w[1:0], rd(crm_pkg::CRM_ADDR_FREQ_MODE_0)};

  // ==========================================================================
  // One monitor per reference. The mode field picks the profile whose limits
  // apply; auto and reserved modes leave the monitor idle. Profile B has no
  // frequency limits in this bank, so only its single-cycle check runs.
  for (genvar r = 0; r < crm_pkg::CRM_NUM_REFS; r++) begin : g_mon
    crm_pkg::crm_mode_t mode_w; // Mode of this reference.
    logic is_a_w; // Reference follows profile A.
    logic is_b_w; // Reference follows profile B.
    logic [7:0] prescale_w; // Profile A prescale register.

    assign mode_w = crm_pkg::crm_mode_t'(input_frequency_select_o[r*2 +: 2]);
    assign is_a_w = (mode_w == crm_pkg::CRM_MODE_PROF_A);
    assign is_b_w = (mode_w == crm_pkg::CRM_MODE_PROF_B);
    assign prescale_w = rd(crm_pkg::CRM_ADDR_A_PRESCALE);

    crm_ref_mon u_mon (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ref_i(ref_clk_i[r]),
      .enable_i(is_a_w || is_b_w),
      .freq_check_i(is_a_w),
      .prescale_i(is_a_w && prescale_w[0]),
      .per_low_i(is_a_w ? rd(crm_pkg::CRM_ADDR_A_PER_LOW) : rd(crm_pkg::CRM_ADDR_B_PER_LOW)),
      .per_high_i(is_a_w ? rd(crm_pkg::CRM_ADDR_A_PER_HIGH) : rd(crm_pkg::CRM_ADDR_B_PER_HIGH)),
      .frq_low_i(a_frq_low_w),
      .frq_high_i(a_frq_high_w),
      .cycles_i(rd(crm_pkg::CRM_ADDR_A_CYCLES)),
      .fail_o(ref_fail_o[r])
    );
  end

endmodule
`default_nettype wire

/* File: test/crm_reg_bank_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Port checker for the configuration bank.
module crm_reg_bank_chk (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [4:0] ref_clk_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [4:0] ref_fail_o,
  input wire logic [9:0] input_frequency_select_o,
  input wire logic [13:0] prof_a_multiplier_o,
  input wire logic [13:0] prof_b_multiplier_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // A write strobe aimed at one address.
  sequence s_wr(logic [7:0] a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  // A read strobe aimed at one address.
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  b_mult_lo_a: assert property (s_wr(8'h71) |=> prof_b_multiplier_o[7:0] == $past(reg_wdata_i))
    else $error("profile B multiplier low byte wrong");
  b_mult_hi_a: assert property (s_wr(8'h72) |=> prof_b_multiplier_o[13:8] == $past(reg_wdata_i[5:0]))
    else $error("profile B multiplier high bits wrong");
  b_mult_rd_a: assert property (s_rd(8'h72) |=> reg_rdata_o == {2'b00, $past(prof_b_multiplier_o[13:8])})
    else $error("profile B multiplier readback wrong");
  a_mult_lo_a: assert property (s_wr(8'h67) |=> prof_a_multiplier_o[7:0] == $past(reg_wdata_i))
    else $error("profile A multiplier low byte wrong");
  mult_hold_a: assert property (!reg_wr_i |=> $stable(prof_a_multiplier_o) && $stable(prof_b_multiplier_o))
    else $error("multiplier moved without a write");
  mode_low_a: assert property (s_wr(8'h65) |=> input_frequency_select_o[7:0] == $past(reg_wdata_i))
    else $error("mode fields 0 to 3 wrong");
  mode_high_a: assert property (s_wr(8'h66) |=> input_frequency_select_o[9:8] == $past(reg_wdata_i[1:0]))
    else $error("mode field 4 wrong");
  rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  unmapped_rd_a: assert property (reg_rd_i && (reg_addr_i < 8'h65 || reg_addr_i > 8'h74) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  no_fail_a: assert property ((input_frequency_select_o[1:0] inside {2'h0, 2'h3}) [*2] |-> !ref_fail_o[0])
    else $error("reference outside custom profiles failed");
endmodule
// The checker sees the bank's ports only.
bind crm_reg_bank crm_reg_bank_chk u_chk (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
  .ref_clk_i, .reg_rdata_o, .ref_fail_o, .input_frequency_select_o, .prof_a_multiplier_o, .prof_b_multiplier_o);
`default_nettype wire

/* File: test/crm_ref_src.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Reference sources: five synchronous lines sharing one period in clocks.
module crm_ref_src (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] period_i,
  output logic [4:0] ref_o
);
  logic [7:0] cnt_q; // Clocks since the last rising edge.
  // One high cycle per period; a zero period stands the lines still and low.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= 8'h00;
      ref_o <= 5'h00;
    end else if (period_i == 8'h00) begin
      cnt_q <= 8'h00;
      ref_o <= 5'h00;
    end else begin
      cnt_q <= (cnt_q + 8'h01 >= period_i) ? 8'h00 : cnt_q + 8'h01;
      ref_o <= {5{cnt_q == 8'h00}};
    end
  end
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Self-checking bench for the configuration bank.
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] period = 8'h00; // Reference period in clocks, zero is still.
  logic [4:0] ref_clk;
  logic [7:0] reg_rdata_o;
  logic [4:0] ref_fail_o;
  logic [9:0] input_frequency_select_o;
  logic [13:0] prof_a_multiplier_o;
  logic [13:0] prof_b_multiplier_o;
  logic [7:0] img [8'h64:8'h75]; // Expected register image.
  logic [7:0] d;
  logic [15:0] cfg [12] = '{16'h6903, 16'h6A05, 16'h6B00, 16'h6C00, 16'h6DFF, 16'h6EFF,
    16'h6F02, 16'h7000, 16'h7304, 16'h74FF, 16'h65C9, 16'h6601};
  integer seed = 76;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  always #2 clk_i = ~clk_i;
  crm_reg_bank uut (.clk_i, .sys_rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .ref_clk_i(ref_clk),
    .reg_rdata_o, .ref_fail_o, .input_frequency_select_o, .prof_a_multiplier_o, .prof_b_multiplier_o);
  crm_ref_src src (.clk_i, .sys_rst_i, .period_i(period), .ref_o(ref_clk));
  // ==========================================================================
  // Closing report, comparison and bus tasks.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Writable bits per address; unmapped addresses keep nothing.
  function automatic logic [7:0] wmask(input logic [7:0] a);
    case (a)
      8'h66: wmask = 8'h03;
      8'h68, 8'h72: wmask = 8'h3F;
      8'h70: wmask = 8'h01;
      default: wmask = (a >= 8'h65 && a <= 8'h74) ? 8'hFF : 8'h00;
    endcase
  endfunction
  // Strobes are held over exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = v;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  // Read data is sampled one and a half cycles after the strobe edge, where it stands.
  task automatic rd(input logic [7:0] a);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
  endtask
  // Long settle so several windows have closed before the verdict is read.
  task automatic step(input logic [7:0] p, input logic [4:0] exp);
    period = p;
    repeat (300) @(negedge clk_i);
    chk(16'(ref_fail_o), 16'(exp));
  endtask
  // A hang counts as a mismatch.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (5) @(negedge clk_i);
    sys_rst_i = 1'b0;
    for (int a = 8'h63; a <= 8'h76; a++) begin
      rd(a[7:0]);
      chk(16'(reg_rdata_o), 16'h0000);
    end
    // First round writes all ones into reserved and unmapped bits, then random data.
    for (int r = 0; r < 4; r++) begin
      for (int a = 8'h64; a <= 8'h75; a++) begin
        d = (r == 0) ? 8'hFF : 8'($random(seed));
        wr(a[7:0], d);
        img[a] = d & wmask(a[7:0]);
        rd(a[7:0]);
        chk(16'(reg_rdata_o), 16'(img[a]));
      end
      chk(16'(prof_b_multiplier_o), {2'b00, img[8'h72][5:0], img[8'h71]});
      chk(16'(prof_a_multiplier_o), {2'b00, img[8'h68][5:0], img[8'h67]});
      chk(16'(input_frequency_select_o), {6'h00, img[8'h66][1:0], img[8'h65]});
    end
    // Refs 0 and 4 on profile A, ref 1 on B, ref 2 automatic, ref 3 reserved.
    foreach (cfg[i]) wr(cfg[i][15:8], cfg[i][7:0]);
    step(8'h05, 5'h00);
    step(8'h03, 5'h13);
    step(8'h07, 5'h11);
    wr(8'h69, 8'h00);
    wr(8'h6A, 8'hFF);
    wr(8'h6B, 8'h12);
    wr(8'h6D, 8'h12);
    wr(8'h6E, 8'h00);
    step(8'h06, 5'h00);
    wr(8'h70, 8'h01);
    step(8'h06, 5'h11);
    wr(8'h6B, 8'h48);
    wr(8'h6D, 8'h48);
    step(8'h06, 5'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
